/* File: rtl/drc_dual_controller.sv */
// Operation
// - Above bend one use the upper slope, below it the lower slope.
// - With gating on, shape levels below bend two by the expansion slope.
// - Optional bend two output point inserts a vertical attenuation step.
// - Compression slope one is unity gain, below one compresses, zero is flat.
// - Expansion slope one is unity gain, above one expands.
// - The gating region exists only while gating is enabled.
// - Gating off ignores bend two and expansion; lower slope runs down.
// - Output point off puts bend two on the lower compression line.
// - Bend one sits at the programmed input and output levels.
// - Zero level output equals bend one output minus input times upper slope.
// - Gain never falls below the compression floor in compression regions.
// - In the gating region the gate floor limits attenuation.
// - Gain never exceeds the programmed ceiling.
// - The static curve uses the averaged level; anti-clip reacts to single samples.
// - Gain falls at the fall rate and rises at the rise rate.
// - Anti-clip looks ahead and speeds the gain fall to avoid clipping.
// - Anti-clip adds look-ahead latency to the sample path.
// - With fast recovery on, the crest factor is measured continuously.
// - Crest factor over threshold swaps in the fast recovery rate.
// - Activity detector compares peak or average level against a threshold.
// - Activity above threshold drives an event output for interrupt or pin.
// - Two identical stereo controllers, one per audio interface.
`include "drc_defines.svh"

module drc_dual_controller
    import drc_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    // Register port.
    input  wire logic [5:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    output logic      [31:0] reg_rdata_o,
    // Sample streams, one per audio interface.
    input  wire logic        smp_valid_i [2],
    input  drc_sample_s      smp_i       [2],
    output logic             smp_valid_o [2],
    output drc_sample_s      smp_o       [2],
    // Activity detector.
    output logic             activity_o       [2],
    output logic             activity_event_o [2]
);

    function automatic drc_lvl_t level_of(input logic signed [23:0] s);
        logic [23:0] a;
        drc_lvl_t    r;
        a = s[23] ? 24'(-s) : 24'(s);
        r = `DRC_LVL_SILENT;
        for (int i = 3; i < 24; i++) begin
            if (a[i]) begin
                r = drc_lvl_t'(10'((i - 23) * 8) + 10'(a[i-1 -: 3]));
            end
        end
        return r;
    endfunction

    function automatic logic signed [15:0] slope_mul(input logic signed [15:0] d,
                                                     input logic [3:0] s);
        logic signed [20:0] p;
        p = 21'(d) * $signed({17'h0_0000, s});
        return 16'(p >>> 3);
    endfunction

    function automatic logic signed [23:0] apply_gain(input logic signed [23:0] s,
                                                      input drc_lvl_t g);
        logic signed [47:0] p;
        logic signed [9:0]  sh;
        logic        [7:0]  m;
        unique case (g[2:0])
            3'h0: m = 8'h80;
            3'h1: m = 8'h8b;
            3'h2: m = 8'h98;
            3'h3: m = 8'ha5;
            3'h4: m = 8'hb5;
            3'h5: m = 8'hc5;
            3'h6: m = 8'hd7;
            3'h7: m = 8'hea;
        endcase
        p  = 48'(s) * $signed({40'h00_0000_0000, m});
        sh = g >>> 3;
        if (sh >= 0) begin
            p = p <<< sh[3:0];
        end else begin
            p = p >>> 4'(-sh);
        end
        p = p >>> 7;
        if (p > 48'sh00_0000_7fffff) begin
            return 24'sh7fffff;
        end else if (p < -48'sh00_0000_800000) begin
            return -24'sh800000;
        end
        return p[23:0];
    endfunction

    // Floors and ceiling in level units of 0.75 dB (one octave is 8 units).
    function automatic drc_lvl_t cfloor(input logic [2:0] c);
        unique case (c)
            3'h0:    return 10'sh000;
            3'h2:    return -10'sh018;
            3'h3:    return -10'sh020;
            3'h4:    return -10'sh030;
            default: return -10'sh010;
        endcase
    endfunction

    function automatic drc_lvl_t ceiling(input logic [1:0] c);
        unique case (c)
            2'h0: return 10'sh010;
            2'h1: return 10'sh018;
            2'h2: return 10'sh020;
            2'h3: return 10'sh030;
        endcase
    endfunction

    function automatic drc_lvl_t gfloor(input logic [3:0] c);
        logic [3:0] k;
        k = (c > 4'hc) ? 4'hc : c;
        return drc_lvl_t'(10'({6'h00, k} * 10'h008) - 10'h030);
    endfunction

    logic [31:0] rd_word [2];

    for (genvar g = 0; g < 2; g++) begin : ctl
        logic [31:0] ctrl_r;
        logic [31:0] rate_r;
        logic [31:0] bend1_r;
        logic [31:0] bend2_r;
        logic [31:0] shape_r;
        drc_lvl_t    rms_r;
        drc_lvl_t    peak_r;
        drc_lvl_t    gain_r;
        logic [15:0] cnt_r;
        drc_sample_s dly_r [`DRC_LOOK];
        drc_sample_s out_r;
        logic        ovld_r;
        logic        act_r;
        logic        act_event_r;

        logic        wr;
        drc_lvl_t    inst;
        drc_lvl_t    b1_in;
        drc_lvl_t    b1_out;
        drc_lvl_t    b2_in;
        drc_lvl_t    b2_out;
        drc_lvl_t    floor_lvl;
        drc_lvl_t    ceil_lvl;
        drc_lvl_t    target;
        drc_lvl_t    gain_nxt;
        drc_lvl_t    y0;
        drc_lvl_t    meas;
        logic        in_gate;
        logic        fast;
        logic [3:0]  rate;
        logic signed [15:0] y;
        logic signed [15:0] y2;
        logic signed [15:0] tgt;
        logic signed [15:0] crest;

        assign wr = reg_write_i && (reg_addr_i[5] == 1'(g));

        always_ff @(posedge clock_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                ctrl_r  <= `DRC_CTRL_RST;
                rate_r  <= `DRC_RATE_RST;
                bend1_r <= `DRC_BEND1_RST;
                bend2_r <= `DRC_BEND2_RST;
                shape_r <= `DRC_SHAPE_RST;
            end else if (wr) begin
                unique case (reg_addr_i[4:0])
                    `DRC_OFS_CTRL:  ctrl_r  <= reg_wdata_i;
                    `DRC_OFS_RATE:  rate_r  <= reg_wdata_i;
                    `DRC_OFS_BEND1: bend1_r <= reg_wdata_i;
                    `DRC_OFS_BEND2: bend2_r <= reg_wdata_i;
                    `DRC_OFS_SHAPE: shape_r <= reg_wdata_i;
                    default:        ;
                endcase
            end
        end

        assign b1_in  = bend1_r[`DRC_BEND_IN  +: 10];
        assign b1_out = bend1_r[`DRC_BEND_OUT +: 10];
        assign b2_in  = bend2_r[`DRC_BEND_IN  +: 10];
        assign b2_out = bend2_r[`DRC_BEND_OUT +: 10];
        assign inst   = level_of(smp_i[g].left) > level_of(smp_i[g].right)
                      ? level_of(smp_i[g].left) : level_of(smp_i[g].right);

        // Static curve driven by the averaged level, never a single sample.
        always_comb begin
            y2 = 16'(b1_out) + slope_mul(16'(b2_in) - 16'(b1_in),
                                         shape_r[`DRC_SHP_LO +: 4]);
            if (ctrl_r[`DRC_CTRL_B2OE]) begin
                y2 = 16'(b2_out);
            end
            in_gate = ctrl_r[`DRC_CTRL_GATE] && (rms_r < b2_in);
            if (rms_r >= b1_in) begin
                y = 16'(b1_out) + slope_mul(16'(rms_r) - 16'(b1_in),
                                            shape_r[`DRC_SHP_HI +: 4]);
            end else if (!in_gate) begin
                y = 16'(b1_out) + slope_mul(16'(rms_r) - 16'(b1_in),
                                            shape_r[`DRC_SHP_LO +: 4]);
            end else begin
                y = y2 + ((16'(rms_r) - 16'(b2_in))
                          <<< shape_r[`DRC_SHP_EXP +: 2]);
            end
            tgt       = y - 16'(rms_r);
            floor_lvl = in_gate ? gfloor(rate_r[`DRC_RATE_GFLR +: 4])
                                : cfloor(rate_r[`DRC_RATE_CFLR +: 3]);
            ceil_lvl  = ceiling(rate_r[`DRC_RATE_CEIL +: 2]);
            if (tgt > 16'(ceil_lvl)) begin
                target = ceil_lvl;
            end else if (tgt < 16'(floor_lvl)) begin
                target = floor_lvl;
            end else begin
                target = tgt[9:0];
            end
        end

        assign y0 = drc_lvl_t'(b1_out - 10'(slope_mul(16'(b1_in),
                               shape_r[`DRC_SHP_HI +: 4])));

        // A high crest factor marks a transient, so recovery may go faster.
        assign crest = 16'(peak_r) - 16'(rms_r);
        assign fast  = ctrl_r[`DRC_CTRL_FREC]
                    && (crest > $signed({8'h00, shape_r[`DRC_SHP_CREST +: 8]}));

        always_comb begin
            if (target < gain_r) begin
                rate = rate_r[`DRC_RATE_FALL +: 4];
            end else if (fast) begin
                rate = rate_r[`DRC_RATE_FREC +: 4];
            end else begin
                rate = rate_r[`DRC_RATE_RISE +: 4];
            end
            gain_nxt = gain_r;
            if (cnt_r >= ((16'h0001 << rate) - 16'h0001)) begin
                if (target < gain_r) begin
                    gain_nxt = gain_r - 10'sh001;
                end else if (target > gain_r) begin
                    gain_nxt = gain_r + 10'sh001;
                end
            end
            // The look-ahead sample would clip: drop the gain at once.
            if (ctrl_r[`DRC_CTRL_ACLIP] && (inst + gain_nxt > 10'sh000)) begin
                gain_nxt = -inst;
            end
            if (gain_nxt > ceil_lvl) begin
                gain_nxt = ceil_lvl;
            end else if (gain_nxt < floor_lvl) begin
                gain_nxt = floor_lvl;
            end
        end

        always_ff @(posedge clock_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                rms_r  <= `DRC_LVL_SILENT;
                peak_r <= `DRC_LVL_SILENT;
                gain_r <= 10'sh000;
                cnt_r  <= 16'h0000;
            end else if (smp_valid_i[g]) begin
                rms_r  <= rms_r + ((inst - rms_r) >>> `DRC_AVG_SHIFT);
                peak_r <= (inst > peak_r) ? inst
                        : (peak_r > `DRC_LVL_SILENT) ? peak_r - 10'sh001 : peak_r;
                if (!ctrl_r[`DRC_CTRL_ENA]) begin
                    gain_r <= 10'sh000;
                    cnt_r  <= 16'h0000;
                end else begin
                    gain_r <= gain_nxt;
                    cnt_r  <= (gain_nxt != gain_r) ? 16'h0000 : cnt_r + 16'h0001;
                end
            end
        end

        // Look-ahead line; its length is the extra latency of anti-clip.
        always_ff @(posedge clock_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                for (int i = 0; i < `DRC_LOOK; i++) begin
                    dly_r[i] <= '0;
                end
            end else if (smp_valid_i[g]) begin
                dly_r[0] <= smp_i[g];
                for (int i = 1; i < `DRC_LOOK; i++) begin
                    dly_r[i] <= dly_r[i-1];
                end
            end
        end

        always_ff @(posedge clock_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                out_r  <= '0;
                ovld_r <= 1'b0;
            end else begin
                ovld_r <= smp_valid_i[g];
                if (smp_valid_i[g]) begin
                    if (ctrl_r[`DRC_CTRL_ACLIP]) begin
                        out_r.left  <= apply_gain(dly_r[`DRC_LOOK-1].left, gain_r);
                        out_r.right <= apply_gain(dly_r[`DRC_LOOK-1].right, gain_r);
                    end else begin
                        out_r.left  <= apply_gain(smp_i[g].left, gain_r);
                        out_r.right <= apply_gain(smp_i[g].right, gain_r);
                    end
                end
            end
        end

        assign meas = shape_r[`DRC_SHP_ACT +: 10];

        always_ff @(posedge clock_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                act_r       <= 1'b0;
                act_event_r <= 1'b0;
            end else begin
                act_event_r <= 1'b0;
                if (smp_valid_i[g]) begin
                    act_r       <= (ctrl_r[`DRC_CTRL_ASEL] ? rms_r : peak_r) > meas;
                    act_event_r <= !act_r
                                && ((ctrl_r[`DRC_CTRL_ASEL] ? rms_r : peak_r) > meas);
                end
            end
        end

        assign smp_valid_o[g]      = ovld_r;
        assign smp_o[g]            = out_r;
        assign activity_o[g]       = act_r;
        assign activity_event_o[g] = act_event_r;

        always_comb begin
            unique case (reg_addr_i[4:0])
                `DRC_OFS_CTRL:  rd_word[g] = ctrl_r;
                `DRC_OFS_RATE:  rd_word[g] = rate_r;
                `DRC_OFS_BEND1: rd_word[g] = bend1_r;
                `DRC_OFS_BEND2: rd_word[g] = bend2_r;
                `DRC_OFS_SHAPE: rd_word[g] = shape_r;
                `DRC_OFS_STAT:  rd_word[g] = {1'b0, act_r, y0, rms_r, gain_r};
                default:        rd_word[g] = 32'h0000_0000;
            endcase
        end
    end

    // Read data stands for exactly the cycle after the read strobe.
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_read_i) begin
            reg_rdata_o <= rd_word[reg_addr_i[5]];
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

endmodule

/* File: rtl/drc_defines.svh */
`ifndef DRC_DEFINES_SVH
`define DRC_DEFINES_SVH

// Register offsets inside one controller window; controllers sit 0x20 apart.
`define DRC_OFS_CTRL   5'h00
`define DRC_OFS_RATE   5'h04
`define DRC_OFS_BEND1  5'h08
`define DRC_OFS_BEND2  5'h0c
`define DRC_OFS_SHAPE  5'h10
`define DRC_OFS_STAT   5'h14

// Control register bits.
`define DRC_CTRL_GATE  0
`define DRC_CTRL_B2OE  1
`define DRC_CTRL_FREC  2
`define DRC_CTRL_ACLIP 3
`define DRC_CTRL_ASEL  4
`define DRC_CTRL_ENA   5

// Rate register fields (least significant bit).
`define DRC_RATE_FALL  0
`define DRC_RATE_RISE  4
`define DRC_RATE_FREC  8
`define DRC_RATE_CFLR  12
`define DRC_RATE_CEIL  16
`define DRC_RATE_GFLR  20

// Bend and shape fields.
`define DRC_BEND_IN    0
`define DRC_BEND_OUT   16
`define DRC_SHP_HI     0
`define DRC_SHP_LO     4
`define DRC_SHP_EXP    8
`define DRC_SHP_CREST  12
`define DRC_SHP_ACT    20

// Reset values.
`define DRC_CTRL_RST   32'h0000_000c
`define DRC_RATE_RST   32'h0001_1324
`define DRC_BEND1_RST  32'h03e0_03e0
`define DRC_BEND2_RST  32'h0390_0390
`define DRC_SHAPE_RST  32'h2e01_8048

// Timing and level constants.
`define DRC_LOOK       4
`define DRC_LVL_SILENT 10'sh340
`define DRC_AVG_SHIFT  4

`endif

/* File: rtl/drc_pkg.sv */
package drc_pkg;
    typedef logic signed [9:0] drc_lvl_t;

    typedef struct packed {
        logic signed [23:0] left;
        logic signed [23:0] right;
    } drc_sample_s;
endpackage

/* File: bench/drc_source.sv */
module drc_source
    import drc_pkg::*;
(
    // Clock and reset.
    input  wire logic       clock_i,
    input  wire logic       rst_b_i,
    // Stream kind: 0 idle, 1 silence, 2 full scale, 3 random.
    input  wire logic [1:0] mode_i,
    // Sample streams, the same data on both interfaces.
    output logic            smp_valid_o [2],
    output drc_sample_s     smp_o       [2]
);
    timeunit 1ns;
    timeprecision 1ns;
    integer      seed = 32'hb28ffeb0;
    drc_sample_s nxt;
    // Between samples the data lines toggle, so nothing may lean on stale data.
    always @(posedge clock_i or negedge rst_b_i) begin
        nxt.left = 24'($random(seed));
        nxt.right = 24'($random(seed));
        if (mode_i == 2'd1) nxt = '0;
        if (mode_i == 2'd2) nxt = {24'h7fffff, 24'h7fffff};
        for (int g = 0; g < 2; g++) begin
            smp_valid_o[g] <= rst_b_i && (mode_i != 2'd0);
            if (!rst_b_i) smp_o[g] <= '0;
            else if (mode_i == 2'd0) smp_o[g] <= ~smp_o[g];
            else smp_o[g] <= nxt;
        end
    end
endmodule

/* File: bench/drc_monitor.sv */
module drc_monitor
    import drc_pkg::*;
(
    // Clock and reset.
    input wire logic        clock_i,
    input wire logic        rst_b_i,
    // Register port.
    input wire logic [5:0]  reg_addr_i,
    input wire logic        reg_read_i,
    input wire logic [31:0] reg_rdata_o,
    // Streams and activity.
    input wire logic        smp_valid_i      [2],
    input wire logic        smp_valid_o      [2],
    input wire drc_sample_s smp_o            [2],
    input wire logic        activity_o       [2],
    input wire logic        activity_event_o [2]
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    AST_VALID_LAT0: assert property (smp_valid_i[0] |=> smp_valid_o[0])
        else $error("stream 0 output valid missing");
    AST_VALID_LAT1: assert property (smp_valid_i[1] |=> smp_valid_o[1])
        else $error("stream 1 output valid missing");
    AST_NO_EXTRA: assert property (smp_valid_o[0] |-> $past(smp_valid_i[0]))
        else $error("stream 0 output valid without input");
    AST_HOLD: assert property (!smp_valid_o[0] |-> $stable(smp_o[0]))
        else $error("stream 0 data moved between samples");
    AST_RD_IDLE: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0)
        else $error("read data not zero outside answer cycle");
    AST_STAT_ACT: assert property (reg_read_i && reg_addr_i == 6'h14
        |=> reg_rdata_o[30] == $past(activity_o[0])) else $error("status activity mismatch");
    AST_EVT_PULSE: assert property (activity_event_o[0]
        |-> activity_o[0] ##1 !activity_event_o[0]) else $error("event not a single pulse");
    AST_EVT_RISE: assert property (activity_event_o[1] |-> !$past(activity_o[1]))
        else $error("event without rising activity");
    AST_ACT_PACE: assert property ($changed(activity_o[0])
        |-> $past(smp_valid_i[0]) || $past(smp_valid_i[0], 2))
        else $error("activity changed without a sample");
    AST_GAIN_RANGE: assert property (reg_read_i && reg_addr_i[4:0] == 5'h14
        |=> $signed(reg_rdata_o[9:0]) >= -10'sd48 && $signed(reg_rdata_o[9:0]) <= 10'sd48)
        else $error("gain outside floor and ceiling");
    cover property (activity_event_o[0]);
    cover property (reg_read_i && reg_addr_i == 6'h34);
    cover property (smp_valid_o[1] ##1 smp_valid_o[1]);
endmodule

bind drc_dual_controller drc_monitor u_drc_monitor (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .smp_valid_i(smp_valid_i),
    .smp_valid_o(smp_valid_o), .smp_o(smp_o), .activity_o(activity_o),
    .activity_event_o(activity_event_o));

/* File: bench/drc_dual_controller_test.sv */
`include "drc_defines.svh"

module drc_dual_controller_test
    import drc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_i     = 1'b0;
    logic        rst_b_i     = 1'b0;
    logic [5:0]  reg_addr_i  = 6'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_write_i = 1'b0;
    logic        reg_read_i  = 1'b0;
    logic [1:0]  mode        = 2'd0;
    logic [31:0] reg_rdata_o;
    logic        smp_valid_i [2];
    drc_sample_s smp_i [2];
    logic        smp_valid_o [2];
    drc_sample_s smp_o [2];
    logic        activity_o [2];
    logic        activity_event_o [2];
    int          miscompares = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          events = 0;
    int          delay = -1;
    int          nout = 0;
    integer      seed = 32'hb28ffeb0;
    logic [47:0] hist [$];
    logic [31:0] rst_val [5] = '{`DRC_CTRL_RST, `DRC_RATE_RST, `DRC_BEND1_RST,
                                 `DRC_BEND2_RST, `DRC_SHAPE_RST};

    always #50 clock_i = ~clock_i;

    drc_source u_drc_source (.clock_i(clock_i), .rst_b_i(rst_b_i), .mode_i(mode),
        .smp_valid_o(smp_valid_i), .smp_o(smp_i));
    drc_dual_controller u_drc_dual_controller (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
        .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .smp_valid_i(smp_valid_i),
        .smp_i(smp_i), .smp_valid_o(smp_valid_o), .smp_o(smp_o),
        .activity_o(activity_o), .activity_event_o(activity_event_o));

    function automatic int floor_of(input int code);
        case (code)
            0: return 0;
            2: return -24;
            3: return -32;
            4: return -48;
            default: return -16;
        endcase
    endfunction

    task automatic end_of_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clock_i);
        reg_write_i <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clock_i);
        reg_read_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    task automatic wr_both(input logic [4:0] a, input logic [31:0] d);
        wr({1'b0, a}, d);
        wr({1'b1, a}, d);
    endtask

    // Reads the gain or the zero-level output of both controllers.
    task automatic stat_chk(input int exp, input bit y0);
        logic [31:0] d;
        for (int c = 0; c < 2; c++) begin
            rd({c[0], 5'h14}, d);
            check({38'h0, y0 ? d[29:20] : d[9:0]}, {38'h0, 10'(exp)});
        end
    endtask

    // Idle gaps keep register writes away from gain updates.
    task automatic run(input logic [1:0] m, input int n);
        @(posedge clock_i);
        mode <= m;
        repeat (n) @(posedge clock_i);
        mode <= 2'd0;
        repeat (3) @(posedge clock_i);
    endtask

    always @(posedge clock_i) begin
        if (smp_valid_i[0]) hist.push_back(smp_i[0]);
        if (smp_valid_o[0] && delay >= 0) begin
            if (nout >= delay) begin
                check(smp_o[0], hist[nout - delay]);
                check(smp_o[1], hist[nout - delay]);
            end
            nout++;
        end
        if (activity_event_o[0] === 1'b1) events++;
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        logic [31:0] d;
        int          bi;
        int          bo;
        int          s;
        repeat (6) @(posedge clock_i);
        rst_b_i <= 1'b1;
        for (int c = 0; c < 2; c++) begin
            for (int o = 0; o < 5; o++) begin
                rd({c[0], 5'(o * 4)}, d);
                check({16'h0, d}, {16'h0, rst_val[o]});
            end
        end
        wr(6'h3c, 32'hffffffff);
        rd(6'h3c, d);
        check({16'h0, d}, 48'h0);
        for (int k = 0; k < 8; k++) begin
            bi = -8 * int'($unsigned($random(seed)) % 9);
            bo = -int'($unsigned($random(seed)) % 64);
            s = int'($unsigned($random(seed)) % 16);
            wr_both(5'h08, {6'h0, 10'(bo), 6'h0, 10'(bi)});
            wr_both(5'h10, 32'h2e018000 | 32'(s));
            stat_chk(bo - bi * s / 8, 1'b1);
        end
        wr_both(5'h00, 32'h00000020);
        wr_both(5'h08, 32'h03a003a0);
        // Flat upper slope and an activity threshold above silence.
        wr_both(5'h10, 32'h3c018000);
        for (int f = 0; f < 6; f++) begin
            wr_both(5'h04, 32'(f << 12) | 32'h00030000);
            run(2'd2, 100);
            stat_chk(floor_of(f), 1'b0);
        end
        check({46'h0, activity_o[1], activity_o[0]}, 48'h3);
        check(48'(events), 48'h1);
        for (int c = 0; c < 5; c++) begin
            wr_both(5'h04, 32'h00001000 | 32'((c % 4) << 16));
            run(2'd1, 200);
            stat_chk(c == 2 ? 32 : c == 1 ? 24 : c == 3 ? 48 : 16, 1'b0);
        end
        check({46'h0, activity_o[1], activity_o[0]}, 48'h0);
        // Gate floor sits below the compression floor here, so only it allows this gain.
        wr_both(5'h00, 32'h00000021);
        wr_both(5'h04, 32'h00430000);
        wr_both(5'h10, 32'h3c018300);
        run(2'd1, 200);
        stat_chk(-16, 1'b0);
        wr_both(5'h00, 32'h00000023);
        wr_both(5'h04, 32'h00030000);
        wr_both(5'h0c, 32'h03000390);
        wr_both(5'h10, 32'h3c018000);
        run(2'd1, 100);
        stat_chk(-48, 1'b0);
        wr_both(5'h00, 32'h00000021);
        run(2'd1, 100);
        stat_chk(16, 1'b0);
        wr_both(5'h00, 32'h00000020);
        run(2'd1, 200);
        stat_chk(48, 1'b0);
        // A full-scale burst on top of a high gain must pull the gain down at once.
        wr_both(5'h00, 32'h00000028);
        run(2'd2, 5);
        stat_chk(1, 1'b0);
        // The normal rise rate is far too slow here; only fast recovery reaches the ceiling.
        wr_both(5'h00, 32'h00000034);
        wr_both(5'h04, 32'h000000f0);
        wr_both(5'h10, 32'h3c000000);
        run(2'd1, 50);
        stat_chk(16, 1'b0);
        check({46'h0, activity_o[1], activity_o[0]}, 48'h0);
        wr_both(5'h04, 32'h000000f0);
        run(2'd3, 100);
        stat_chk(0, 1'b0);
        for (int a = 0; a < 2; a++) begin
            wr_both(5'h00, a ? 32'h00000028 : 32'h00000020);
            hist.delete();
            nout = 0;
            delay = a ? `DRC_LOOK : 0;
            run(2'd3, 50);
            delay = -1;
        end
        end_of_test();
    end
endmodule
